// file: rtl/dsc_regs.svh
/*
 * Register offsets, field positions, reset values and command codes of the
 * disk string control unit.
 * Assumes inclusion by bare name from the main module.
 */
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

// Register byte offsets
`define DSC_REG_CTRL      8'h00
`define DSC_REG_THRESH    8'h04
`define DSC_REG_RPO       8'h08
`define DSC_REG_ACTIVE    8'h0c
`define DSC_REG_XFER      8'h10
`define DSC_REG_PEND      8'h14
`define DSC_REG_ORIENT    8'h18
`define DSC_REG_OFFLINE   8'h1c

// Control register fields
`define DSC_CTRL_SHARED   0
`define DSC_CTRL_DEDSEL   1

// Reset values
`define DSC_CTRL_RST      32'h0000_0000
`define DSC_THRESH_RST    16'hff00
`define DSC_RPO_RST       32'h0000_0000

// Status bits of a response word
`define DSC_ST_UC         3
`define DSC_ST_BUSY       2
`define DSC_ST_CE         1
`define DSC_ST_DE         0

// Command codes
`define DSC_CMD_START     8'h01
`define DSC_CMD_END       8'h02
`define DSC_CMD_SEEK      8'h07
`define DSC_CMD_READ      8'h06
`define DSC_CMD_SET_SECT  8'h23
`define DSC_CMD_READ_SECT 8'h22
`define DSC_CMD_SENSE     8'h04
`define DSC_CMD_LOG_FETCH 8'ha4

// Response lengths in bytes
`define DSC_SENSE_LEN     4'h4
`define DSC_LOG_LEN       4'h8

`endif

// file: rtl/dsc_pkg.sv
/*
 * Types shared by the disk string control unit and its response buffer.
 * Assumes the register header is on the include path.
 */
package dsc_pkg;

  typedef logic [4:0]  dsc_drive_type;
  typedef logic [12:0] dsc_rsp_type;   // {last, status[3:0], data[7:0]}

  typedef enum logic {
    DSC_IDLE,
    DSC_EMIT
  } dsc_state_type;

  typedef enum logic {
    DSC_SRC_SENSE,
    DSC_SRC_LOG
  } dsc_src_type;

endpackage : dsc_pkg

// file: rtl/dsc_stream_if.sv
/*
 * Valid/ready word stream between the command engine and the buffer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps

interface dsc_stream_if;
  logic                 valid;
  logic                 ready;
  dsc_pkg::dsc_rsp_type data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dsc_stream_if

// file: rtl/dsc_rsp_buf.sv
/*
 * Two-entry response buffer: head and spare register, all outputs flopped.
 * Assumes a synchronous active-high reset and a common clock enable.
 */
`timescale 1ns/100ps

module dsc_rsp_buf (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  dsc_stream_if.snk                 in_side,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output dsc_pkg::dsc_rsp_type      out_data
);

  logic                 head_v_q, head_v_d, spare_v_q, spare_v_d, rdy_q, rdy_d;
  dsc_pkg::dsc_rsp_type head_q, head_d, spare_q, spare_d;
  logic                 push, pop;

  assign push          = in_side.valid & rdy_q;
  assign pop           = head_v_q & out_ready;
  assign in_side.ready = rdy_q;
  assign out_valid     = head_v_q;
  assign out_data      = head_q;

  always_comb begin
    head_v_d  = head_v_q;
    head_d    = head_q;
    spare_v_d = spare_v_q;
    spare_d   = spare_q;
    if (pop || !head_v_q) begin
      if (spare_v_q) begin
        head_v_d  = 1'b1;
        head_d    = spare_q;
        spare_v_d = push;
        spare_d   = in_side.data;
      end else begin
        head_v_d = push;
        head_d   = in_side.data;
      end
    end else if (push) begin
      spare_v_d = 1'b1;
      spare_d   = in_side.data;
    end
    // Ready drops once the spare holds a word, so a stall loses nothing
    rdy_d = !spare_v_d;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      head_v_q  <= 1'b0;
      spare_v_q <= 1'b0;
      head_q    <= 13'h0000;
      spare_q   <= 13'h0000;
      rdy_q     <= 1'b1;
    end else if (ce) begin
      head_v_q  <= head_v_d;
      spare_v_q <= spare_v_d;
      head_q    <= head_d;
      spare_q   <= spare_d;
      rdy_q     <= rdy_d;
    end
  end

endmodule : dsc_rsp_buf

// file: rtl/dsc_ctrl_unit.sv
/*
 * Command engine of a disk string control unit: per-drive channel programs,
 * one shared transfer path, sector commands, sense and usage logging.
 * Assumes drive pins arrive asynchronously; command, data-path and register
 * ports come from logic on clk.
 */
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "dsc_regs.svh"

// Functional notes
// - Up to 32 programs active together, at most one per drive.
// - Only one drive moves data at a time; others wait.
// - Set-sector without rotational option: no-op, orientation lost, CE and DE.
// - Read-sector without rotational option returns zero with CE and DE.
// - Sense data carries the drive's rotational option bit, readable unless the drive is offline or the other attachment holds the string.
// - Correctable read error: sense carries correction pattern and byte displacement.
// - Per-drive counters: bytes read, seeks, command and data overruns.
// - Threshold or module removal gives unit check at next command other than sense or log fetch, or at ready.
// - Usage-log fetch returns counters then clears them.
// - Maintenance offline ends only on attention button; access returns to track 0.
// - Shared string serves two attachments, one at a time; else dedicated only.
// - No automatic command retry for this drive type.
module dsc_ctrl_unit (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire logic [7:0]           cmd_code,
  input  wire logic [4:0]           cmd_drive,
  input  wire logic                 cmd_attach,
  output logic                      rsp_valid,
  input  wire logic                 rsp_ready,
  output logic      [12:0]          rsp_word,
  input  wire logic                 xfer_done,
  input  wire logic                 byte_strobe,
  input  wire logic                 cmd_overrun,
  input  wire logic                 data_overrun,
  input  wire logic [7:0]           sector_pos,
  input  wire logic                 ecc_valid,
  input  wire logic [4:0]           ecc_drive,
  input  wire logic [7:0]           ecc_pattern,
  input  wire logic [15:0]          ecc_disp,
  input  wire logic [31:0]          module_present,
  input  wire logic [31:0]          maint_switch,
  input  wire logic [31:0]          attn_button,
  output logic                      xfer_active,
  output logic      [4:0]           xfer_owner,
  output logic      [31:0]          rehome
);

  localparam int ND = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges
  logic [95:0] pin_s1_q, pin_s2_q, pin_prev_q;
  logic [31:0] present_s, maint_s, attn_s, removed_evt, ready_evt, attn_evt, maint_evt;

  assign present_s   = pin_s2_q[31:0];
  assign maint_s     = pin_s2_q[63:32];
  assign attn_s      = pin_s2_q[95:64];
  assign removed_evt = pin_prev_q[31:0] & ~present_s;
  assign ready_evt   = ~pin_prev_q[31:0] & present_s;
  assign maint_evt   = ~pin_prev_q[63:32] & maint_s;
  assign attn_evt    = ~pin_prev_q[95:64] & attn_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q   <= 96'h0;
      pin_s2_q   <= 96'h0;
      pin_prev_q <= 96'h0;
    end else if (ce) begin
      pin_s1_q   <= {attn_button, maint_switch, module_present};
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, command decode and response stream
  logic                   shared_q, shared_d, dedsel_q, dedsel_d;
  logic [15:0]            thresh_q, thresh_d;
  logic [31:0]            rpo_q, rpo_d, rdata_q, rdata_d;
  logic [31:0]            active_q, active_d, xreq_q, xreq_d, pend_q, pend_d;
  logic [31:0]            orient_q, orient_d, offline_q, offline_d, rehome_q, rehome_d;
  logic [31:0]            rdyrpt_q, rdyrpt_d;
  logic                   owner_att_q, owner_att_d, xbusy_q, xbusy_d;
  logic [4:0]             xown_q, xown_d, ecc_drv_q, ecc_drv_d;
  logic [7:0]             ecc_pat_q, ecc_pat_d;
  logic [15:0]            ecc_dsp_q, ecc_dsp_d;
  logic [15:0]            cnt_q [4][ND];
  logic [15:0]            cnt_d [4][ND];
  dsc_pkg::dsc_state_type state_q, state_d;
  dsc_pkg::dsc_src_type   src_q, src_d;
  logic [3:0]             idx_q, idx_d, len_q, len_d;
  logic [4:0]             edrv_q, edrv_d;
  logic                   crdy_q, crdy_d, take;
  logic [7:0]             ebyte;
  logic [4:0]             d;
  logic [3:0]             st_ok;
  logic [4:0]             rpt_idx;
  logic                   rpt_any;
  logic [4:0]             gnt_idx;
  logic                   gnt_any;
  dsc_stream_if           rsp_if ();

  assign d     = cmd_drive;
  assign take  = cmd_valid & crdy_q & (state_q == dsc_pkg::DSC_IDLE);
  assign st_ok = 4'h3;

  // Lowest pending ready-report and transfer request win
  always_comb begin
    rpt_idx = 5'h00;
    rpt_any = 1'b0;
    gnt_idx = 5'h00;
    gnt_any = 1'b0;
    for (int i = ND - 1; i >= 0; i--) begin
      if (rdyrpt_q[i]) begin
        rpt_idx = 5'(i);
        rpt_any = 1'b1;
      end
      if (xreq_q[i]) begin
        gnt_idx = 5'(i);
        gnt_any = 1'b1;
      end
    end
  end

  // Byte of a multi-byte sense or log response
  always_comb begin
    ebyte = 8'h00;
    if (src_q == dsc_pkg::DSC_SRC_SENSE) begin
      case (idx_q)
        4'h0: ebyte = {4'h0, offline_q[edrv_q], pend_q[edrv_q], orient_q[edrv_q],
                       rpo_q[edrv_q]};
        4'h1: ebyte = (ecc_drv_q == edrv_q) ? ecc_pat_q : 8'h00;
        4'h2: ebyte = (ecc_drv_q == edrv_q) ? ecc_dsp_q[15:8] : 8'h00;
        4'h3: ebyte = (ecc_drv_q == edrv_q) ? ecc_dsp_q[7:0] : 8'h00;
        default: ebyte = 8'h00;
      endcase
    end else begin
      ebyte = idx_q[0] ? cnt_q[idx_q[2:1]][edrv_q][7:0]
                       : cnt_q[idx_q[2:1]][edrv_q][15:8];
    end
  end

  always_comb begin
    shared_d    = shared_q;
    dedsel_d    = dedsel_q;
    thresh_d    = thresh_q;
    rpo_d       = rpo_q;
    rdata_d     = 32'h0;
    active_d    = active_q;
    xreq_d      = xreq_q;
    orient_d    = orient_q;
    owner_att_d = owner_att_q;
    xbusy_d     = xbusy_q;
    xown_d      = xown_q;
    ecc_drv_d   = ecc_drv_q;
    ecc_pat_d   = ecc_pat_q;
    ecc_dsp_d   = ecc_dsp_q;
    state_d     = state_q;
    src_d       = src_q;
    idx_d       = idx_q;
    len_d       = len_q;
    edrv_d      = edrv_q;
    cnt_d       = cnt_q;
    rsp_if.valid = 1'b0;
    rsp_if.data  = 13'h0000;
    pend_d      = pend_q;
    rdyrpt_d    = rdyrpt_q;
    offline_d   = offline_q;
    rehome_d    = 32'h0;

    if (reg_wr) begin
      case (reg_addr)
        `DSC_REG_CTRL: begin
          shared_d = reg_wdata[`DSC_CTRL_SHARED];
          dedsel_d = reg_wdata[`DSC_CTRL_DEDSEL];
        end
        `DSC_REG_THRESH: thresh_d = reg_wdata[15:0];
        `DSC_REG_RPO:    rpo_d    = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `DSC_REG_CTRL:    rdata_d = {29'h0, owner_att_q, dedsel_q, shared_q};
        `DSC_REG_THRESH:  rdata_d = {16'h0, thresh_q};
        `DSC_REG_RPO:     rdata_d = rpo_q;
        `DSC_REG_ACTIVE:  rdata_d = active_q;
        `DSC_REG_XFER:    rdata_d = {26'h0, xbusy_q, xown_q};
        `DSC_REG_PEND:    rdata_d = pend_q;
        `DSC_REG_ORIENT:  rdata_d = orient_q;
        `DSC_REG_OFFLINE: rdata_d = offline_q;
        default:          rdata_d = 32'h0;
      endcase
    end

    if (ecc_valid) begin
      ecc_drv_d = ecc_drive;
      ecc_pat_d = ecc_pattern;
      ecc_dsp_d = ecc_disp;
    end

    // Single transfer path, fixed order
    if (xbusy_q && xfer_done) begin
      xbusy_d = 1'b0;
    end else if (!xbusy_q && gnt_any) begin
      xbusy_d         = 1'b1;
      xown_d          = gnt_idx;
      xreq_d[gnt_idx] = 1'b0;
    end

    // Usage counters saturate rather than wrap
    if (xbusy_q) begin
      if (byte_strobe && cnt_q[0][xown_q] != 16'hffff) cnt_d[0][xown_q] = cnt_q[0][xown_q] + 16'h1;
      if (cmd_overrun && cnt_q[2][xown_q] != 16'hffff) cnt_d[2][xown_q] = cnt_q[2][xown_q] + 16'h1;
      if (data_overrun && cnt_q[3][xown_q] != 16'hffff) cnt_d[3][xown_q] = cnt_q[3][xown_q] + 16'h1;
    end

    if (state_q == dsc_pkg::DSC_EMIT) begin
      if (rsp_if.ready) begin
        rsp_if.valid = 1'b1;
        rsp_if.data  = {(idx_q == len_q - 4'h1), (idx_q == len_q - 4'h1) ? st_ok : 4'h0, ebyte};
        idx_d = idx_q + 4'h1;
        if (idx_q == len_q - 4'h1) begin
          state_d = dsc_pkg::DSC_IDLE;
          if (src_q == dsc_pkg::DSC_SRC_LOG) begin
            for (int k = 0; k < 4; k++) cnt_d[k][edrv_q] = 16'h0;
          end
        end
      end
    end else if (take) begin
      rsp_if.valid = 1'b1;
      rsp_if.data  = {1'b1, st_ok, 8'h00};
      if (active_q == 32'h0) owner_att_d = cmd_attach;
      // Other attachment is turned away with busy while the string is held
      if ((!shared_q && cmd_attach != dedsel_q) ||
          (shared_q && active_q != 32'h0 && cmd_attach != owner_att_q)) begin
        rsp_if.data = {1'b1, 4'h4, 8'h00};
      end else if (offline_q[d]) begin
        rsp_if.data = {1'b1, 4'hb, 8'h00};
      end else if (pend_q[d] && cmd_code != `DSC_CMD_SENSE &&
                   cmd_code != `DSC_CMD_LOG_FETCH) begin
        // Reported once, never retried by hardware
        rsp_if.data = {1'b1, 4'hb, 8'h00};
        pend_d[d]   = 1'b0;
      end else begin
        case (cmd_code)
          `DSC_CMD_START: begin
            if (active_q[d]) rsp_if.data = {1'b1, 4'h4, 8'h00};
            else active_d[d] = 1'b1;
          end
          `DSC_CMD_END: active_d[d] = 1'b0;
          `DSC_CMD_SEEK: begin
            if (cnt_q[1][d] != 16'hffff) cnt_d[1][d] = cnt_q[1][d] + 16'h1;
            orient_d[d] = 1'b0;
          end
          `DSC_CMD_READ: begin
            xreq_d[d]   = 1'b1;
            rsp_if.data = {1'b1, 4'h2, 8'h00};
          end
          `DSC_CMD_SET_SECT: orient_d[d] = rpo_q[d];
          `DSC_CMD_READ_SECT: rsp_if.data = {1'b1, st_ok, rpo_q[d] ? sector_pos : 8'h00};
          `DSC_CMD_SENSE, `DSC_CMD_LOG_FETCH: begin
            rsp_if.valid = 1'b0;
            state_d = dsc_pkg::DSC_EMIT;
            idx_d   = 4'h0;
            edrv_d  = d;
            src_d   = (cmd_code == `DSC_CMD_SENSE) ? dsc_pkg::DSC_SRC_SENSE
                                                   : dsc_pkg::DSC_SRC_LOG;
            len_d   = (cmd_code == `DSC_CMD_SENSE) ? `DSC_SENSE_LEN : `DSC_LOG_LEN;
          end
          default: rsp_if.data = {1'b1, 4'hb, 8'h00};
        endcase
      end
    end else if (crdy_q && state_q == dsc_pkg::DSC_IDLE && rpt_any) begin
      // Unsolicited unit check when a module comes ready on a flagged drive
      rsp_if.valid      = 1'b1;
      rsp_if.data       = {1'b1, 4'h8, 3'h0, rpt_idx};
      rdyrpt_d[rpt_idx] = 1'b0;
      pend_d[rpt_idx]   = 1'b0;
    end

    // Hardware sets win over clears made above
    for (int i = 0; i < ND; i++) begin
      for (int k = 0; k < 4; k++) begin
        if (cnt_d[k][i] >= thresh_q && cnt_q[k][i] < thresh_q) pend_d[i] = 1'b1;
      end
      if (removed_evt[i]) pend_d[i] = 1'b1;
      if (ready_evt[i] && pend_d[i]) rdyrpt_d[i] = 1'b1;
      if (maint_evt[i]) offline_d[i] = 1'b1;
      if (offline_q[i] && attn_evt[i] && !maint_s[i]) begin
        offline_d[i] = 1'b0;
        rehome_d[i]  = 1'b1;
      end
    end

    crdy_d = (state_d == dsc_pkg::DSC_IDLE) && !rsp_if.valid && rsp_if.ready;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shared_q    <= 1'b0;
      dedsel_q    <= 1'b0;
      thresh_q    <= `DSC_THRESH_RST;
      rpo_q       <= `DSC_RPO_RST;
      rdata_q     <= 32'h0;
      active_q    <= 32'h0;
      xreq_q      <= 32'h0;
      pend_q      <= 32'h0;
      orient_q    <= 32'h0;
      offline_q   <= 32'h0;
      rehome_q    <= 32'h0;
      rdyrpt_q    <= 32'h0;
      owner_att_q <= 1'b0;
      xbusy_q     <= 1'b0;
      xown_q      <= 5'h00;
      ecc_drv_q   <= 5'h00;
      ecc_pat_q   <= 8'h00;
      ecc_dsp_q   <= 16'h0000;
      state_q     <= dsc_pkg::DSC_IDLE;
      src_q       <= dsc_pkg::DSC_SRC_SENSE;
      idx_q       <= 4'h0;
      len_q       <= 4'h1;
      edrv_q      <= 5'h00;
      crdy_q      <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        for (int i = 0; i < ND; i++) cnt_q[k][i] <= 16'h0000;
      end
    end else if (ce) begin
      shared_q    <= shared_d;
      dedsel_q    <= dedsel_d;
      thresh_q    <= thresh_d;
      rpo_q       <= rpo_d;
      rdata_q     <= rdata_d;
      active_q    <= active_d;
      xreq_q      <= xreq_d;
      pend_q      <= pend_d;
      orient_q    <= orient_d;
      offline_q   <= offline_d;
      rehome_q    <= rehome_d;
      rdyrpt_q    <= rdyrpt_d;
      owner_att_q <= owner_att_d;
      xbusy_q     <= xbusy_d;
      xown_q      <= xown_d;
      ecc_drv_q   <= ecc_drv_d;
      ecc_pat_q   <= ecc_pat_d;
      ecc_dsp_q   <= ecc_dsp_d;
      state_q     <= state_d;
      src_q       <= src_d;
      idx_q       <= idx_d;
      len_q       <= len_d;
      edrv_q      <= edrv_d;
      crdy_q      <= crdy_d;
      cnt_q       <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata   = rdata_q;
  assign cmd_ready   = crdy_q;
  assign xfer_active = xbusy_q;
  assign xfer_owner  = xown_q;
  assign rehome      = rehome_q;

  dsc_rsp_buf u_buf (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_side   (rsp_if.snk),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_word)
  );

endmodule : dsc_ctrl_unit

// file: testbench/dsc_ctrl_unit_monitor.sv
/* Port checker of the disk string control unit.
   Assumes ce drops only while the ports are idle, and a bind to the design's top. */
`timescale 1ns/100ps

module dsc_ctrl_unit_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic [12:0] rsp_word,
  input wire logic        xfer_done,
  input wire logic        xfer_active,
  input wire logic [4:0]  xfer_owner,
  input wire logic [31:0] attn_button,
  input wire logic [31:0] rehome
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_RD_SLOT: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  AST_CMD_GAP: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("command taken twice in a row");
  AST_CMD_ANS: assert property (cmd_valid && cmd_ready |-> ##[1:2] rsp_valid)
    else $error("command left unanswered");
  AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_word))
    else $error("stalled response word lost");
  AST_XFER_HOLD: assert property (xfer_active && !xfer_done |=>
    xfer_active && $stable(xfer_owner))
    else $error("transfer path moved before done");
  AST_OWNER_FIX: assert property ($changed(xfer_owner) |->
    !$past(xfer_active) || $past(xfer_done))
    else $error("owner changed while path busy");
  AST_REHOME_PULSE: assert property (rehome != 32'h0 |=> (rehome & $past(rehome)) == 32'h0)
    else $error("rehome longer than one cycle");
  AST_REHOME_CAUSE: assert property (rehome != 32'h0 |->
    (rehome & ($past(attn_button, 3) | $past(attn_button, 5))) == rehome)
    else $error("rehome without button press");
endmodule : dsc_ctrl_unit_monitor

bind dsc_ctrl_unit dsc_ctrl_unit_monitor u_dsc_ctrl_unit_monitor (
  .clk, .rst, .reg_rd, .reg_rdata, .cmd_valid, .cmd_ready, .rsp_valid, .rsp_ready,
  .rsp_word, .xfer_done, .xfer_active, .xfer_owner, .attn_button, .rehome
);

// file: testbench/dsc_host_model.sv
/* Host channel side of the response stream: prompt, or stalling at random.
   Assumes the same clock as the design. */
`timescale 1ns/100ps

module dsc_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  output logic     rsp_ready
);
  integer seed = 16;

  initial rsp_ready = 1'b0;
  // Stalls only delay words, so the buffer must hold every one
  always @(posedge clk) rsp_ready <= !rst && (!slow || ($random(seed) & 3) == 0);
endmodule : dsc_host_model

// file: testbench/tb_top.sv
/* Self-checking bench of the disk string control unit.
   Assumes the host model and the bound port checker. */
`timescale 1ns/100ps

module tb_top;
  logic        clk, rst, ce, slow, reg_wr, reg_rd, cmd_valid, cmd_ready, cmd_attach;
  logic        rsp_valid, rsp_ready, xfer_active;
  logic [4:0]  pl, cmd_drive, ecc_drive, xfer_owner;
  logic [7:0]  reg_addr, cmd_code, sector_pos, ecc_pattern;
  logic [15:0] ecc_disp, nb;
  logic [31:0] reg_wdata, reg_rdata, module_present, maint_switch, attn_button, rehome, rv;
  logic [12:0] rsp_word, w[8], rq[$];
  integer      seed = 16, miscompares = 0, n_tests = 0, i, k;

  dsc_ctrl_unit u_dsc_ctrl_unit (
    .clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_valid,
    .cmd_ready, .cmd_code, .cmd_drive, .cmd_attach, .rsp_valid, .rsp_ready, .rsp_word,
    .xfer_done(pl[3]), .byte_strobe(pl[0]), .cmd_overrun(pl[1]), .data_overrun(pl[2]),
    .sector_pos, .ecc_valid(pl[4]), .ecc_drive, .ecc_pattern, .ecc_disp, .module_present,
    .maint_switch, .attn_button, .xfer_active, .xfer_owner, .rehome
  );
  dsc_host_model u_dsc_host_model (.clk, .rst, .slow, .rsp_ready);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) if (rsp_valid && rsp_ready) rq.push_back(rsp_word);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [12:0] bw(input logic [7:0] b, input logic last);
    bw = {last, last ? 4'h3 : 4'h0, b};
  endfunction : bw

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata, e);
  endtask : rdc

  // Words beyond n are caught, so a silent retry shows up
  task automatic cmd(input logic [7:0] c, input logic [4:0] d, input logic a, input int n);
    int t;
    @(posedge clk);
    rq.delete();
    cmd_code <= c;
    cmd_drive <= d;
    cmd_attach <= a;
    cmd_valid <= 1'b1;
    @(posedge clk);
    for (t = 0; t < 60 && cmd_ready !== 1'b1; t++) @(posedge clk);
    cmd_valid <= 1'b0;
    for (t = 0; t < 80 && rq.size() < n; t++) @(posedge clk);
    repeat (6) @(posedge clk);
    chk(rq.size(), n);
    for (t = 0; t < n; t++) w[t] = rq.size() ? rq.pop_front() : 13'h0;
  endtask : cmd

  task automatic cmdst(input logic [7:0] c, input logic [4:0] d, input logic a,
                       input logic [3:0] s);
    cmd(c, d, a, 1);
    chk(w[0], {1'b1, s, 8'h00});
  endtask : cmdst

  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge clk);
      pl[b] <= 1'b1;
      @(posedge clk);
      pl[b] <= 1'b0;
    end
  endtask : pulse

  task automatic own(input logic [4:0] d);
    for (int t = 0; t < 40 && {xfer_active, xfer_owner} !== {1'b1, d}; t++) @(posedge clk);
    chk({xfer_active, xfer_owner}, {1'b1, d});
  endtask : own

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  initial begin
    {rst, ce, slow, reg_wr, reg_rd, cmd_valid, cmd_attach, pl} = 12'hc00;
    {reg_addr, reg_wdata, cmd_code, cmd_drive, ecc_drive} = '0;
    {sector_pos, ecc_pattern, ecc_disp} = '0;
    {module_present, maint_switch, attn_button} = {32'hffffffff, 64'h0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (120) @(posedge clk);
    chk(rq.size(), 0);
    rdc(8'h04, 32'h0000ff00);
    rdc(8'h08, 32'h0);
    rdc(8'h00, 32'h0);
    rdc(8'h20, 32'h0);
    wr(8'h0c, 32'hffffffff);
    rdc(8'h0c, 32'h0);
    $display("registers done");
    for (i = 0; i < 32; i++) cmdst(8'h01, i[4:0], 1'b0, 4'h3);
    rdc(8'h0c, 32'hffffffff);
    cmdst(8'h01, 5'd3, 1'b0, 4'h4);
    cmdst(8'h02, 5'd4, 1'b1, 4'h4);
    for (i = 0; i < 32; i++) cmdst(8'h02, i[4:0], 1'b0, 4'h3);
    wr(8'h00, 32'h1);
    cmdst(8'h01, 5'd0, 1'b1, 4'h3);
    cmdst(8'h01, 5'd1, 1'b0, 4'h4);
    cmdst(8'h02, 5'd0, 1'b1, 4'h3);
    wr(8'h00, 32'h0);
    $display("programs done");
    slow <= 1'b1;
    sector_pos <= $random(seed);
    cmdst(8'h22, 5'd5, 1'b0, 4'h3);
    wr(8'h08, 32'h20);
    cmdst(8'h23, 5'd5, 1'b0, 4'h3);
    rdc(8'h18, 32'h20);
    wr(8'h08, 32'h0);
    cmdst(8'h23, 5'd5, 1'b0, 4'h3);
    rdc(8'h18, 32'h0);
    $display("sector done");
    {ecc_drive, ecc_pattern, ecc_disp} <= {5'd7, 24'($random(seed))};
    wr(8'h08, 32'h80);
    pulse(4, 1);
    cmd(8'h04, 5'd7, 1'b0, 4);
    chk(w[0], bw(8'h01, 1'b0));
    chk(w[1], bw(ecc_pattern, 1'b0));
    chk(w[2], bw(ecc_disp[15:8], 1'b0));
    chk(w[3], bw(ecc_disp[7:0], 1'b1));
    $display("sense done");
    cmdst(8'h06, 5'd2, 1'b0, 4'h2);
    own(5'd2);
    nb = 16'(($random(seed) & 31) + 1);
    pulse(0, nb);
    pulse(1, 2);
    pulse(2, 1);
    pulse(3, 1);
    for (i = 0; i < 3; i++) cmdst(8'h07, 5'd2, 1'b0, 4'h3);
    cmd(8'ha4, 5'd2, 1'b0, 8);
    for (i = 0; i < 4; i++) begin
      rv = {nb, 16'h3, 16'h2, 16'h1} >> (48 - 16 * i);
      chk(w[2 * i], bw(rv[15:8], 1'b0));
      chk(w[2 * i + 1], bw(rv[7:0], i == 3));
    end
    cmd(8'ha4, 5'd2, 1'b0, 8);
    for (i = 0; i < 8; i++) chk(w[i], bw(8'h00, i == 7));
    $display("usage log done");
    cmdst(8'h06, 5'd6, 1'b0, 4'h2);
    own(5'd6);
    cmdst(8'h06, 5'd9, 1'b0, 4'h2);
    cmdst(8'h06, 5'd4, 1'b0, 4'h2);
    own(5'd6);
    pulse(3, 1);
    own(5'd4);
    pulse(3, 1);
    own(5'd9);
    pulse(3, 1);
    $display("arbitration done");
    wr(8'h04, 32'h3);
    for (i = 0; i < 3; i++) cmd(8'h07, 5'd10, 1'b0, 1);
    rdc(8'h14, 32'h400);
    cmdst(8'h01, 5'd10, 1'b0, 4'hb);
    rdc(8'h14, 32'h0);
    module_present[12] <= 1'b0;
    repeat (10) @(posedge clk);
    rdc(8'h14, 32'h1000);
    cmdst(8'h01, 5'd12, 1'b0, 4'hb);
    // Insert, remove, insert: only the last insert finds a pending condition
    rq.delete();
    for (k = 0; k < 3; k++) begin
      module_present[12] <= ~k[0];
      repeat (40) @(posedge clk);
    end
    chk(rq.size(), 1);
    chk(rq[0], 13'h180c);
    // A write while frozen must not land
    ce <= 1'b0;
    wr(8'h04, 32'h5);
    ce <= 1'b1;
    rdc(8'h04, 32'h3);
    $display("threshold done");
    maint_switch[20] <= 1'b1;
    repeat (10) @(posedge clk);
    rdc(8'h1c, 32'h100000);
    cmdst(8'h01, 5'd20, 1'b0, 4'hb);
    for (k = 0; k < 2; k++) begin
      attn_button[20] <= 1'b1;
      rv = 0;
      repeat (12) @(posedge clk) rv += rehome[20];
      attn_button[20] <= 1'b0;
      chk(rv, k);
      rdc(8'h1c, k ? 32'h0 : 32'h100000);
      maint_switch[20] <= 1'b0;
      repeat (10) @(posedge clk);
    end
    $display("offline done");
    for (i = 0; i < 8; i++) begin
      rv = $random(seed);
      wr(8'h04, rv);
      rdc(8'h04, {16'h0, rv[15:0]});
    end
    $display("random threshold done");
    end_of_test();
  end
endmodule : tb_top
